/* rtl/ast_pkg.sv */
// Operation
// - Transmit and receive buffers are each four characters deep, first-in first-out.
// - Bit timing comes from an internal rate generator with a 16-bit divisor.
// - High-speed select gives four ticks per bit, otherwise sixteen ticks per bit.
// - Format 11 nine bits, 10 odd parity, 01 even parity, 00 eight bits plain.
// - Stop-count select set sends two stop bits, clear sends one.
// - Receive polarity invert set makes logic 0 the receive idle level.
// - Without infrared, transmit polarity invert makes the transmit line idle low.
// - Infrared encoder and decoder work only in sixteen-ticks-per-bit mode.
// - Auto-rate bit measures the next 0x55 character, then hardware clears it.
// - Send-break sends start, twelve zero bits, stop; hardware then clears it.
// - Transmit enable hands over the pin; clearing it aborts and flushes transmit.
// - Transmit-full flag is 1 while the transmit buffer accepts no more characters.
// - Shifter-empty flag is 1 only when shifter and buffer are idle; resets to 1.
// - Address detect in nine-bit mode keeps only characters with ninth bit 1.
// - Receiver-idle flag is 1 while no character is being received; resets to 1.
// - Parity error flag belongs to the character at the receive buffer head.
// - Framing error flag belongs to the character at the receive buffer head.
// - Overrun flag sets on overflow; clearing it empties buffer and receive shifter.
// - Receive-available flag is 1 while the receive buffer holds a character.
// - A separate error interrupt covers all receive error conditions.
package ast_pkg;

  localparam int AST_AW    = 5;
  localparam int AST_DW    = 16;
  localparam int AST_DEPTH = 4;

  localparam logic [AST_AW-1:0] AST_OFS_MODE = 5'h00;
  localparam logic [AST_AW-1:0] AST_OFS_STA  = 5'h04;
  localparam logic [AST_AW-1:0] AST_OFS_TXD  = 5'h08;
  localparam logic [AST_AW-1:0] AST_OFS_RXD  = 5'h0C;
  localparam logic [AST_AW-1:0] AST_OFS_DIV  = 5'h10;

  localparam logic [15:0] AST_MODE_WMASK = 16'hBBFF;
  localparam logic [15:0] AST_STA_WMASK  = 16'hECE0;

  localparam int AST_M_EN    = 15;
  localparam int AST_M_IR    = 12;
  localparam int AST_M_LOOP  = 6;
  localparam int AST_M_ABD   = 5;
  localparam int AST_M_RXINV = 4;
  localparam int AST_M_HS    = 3;
  localparam int AST_M_FMT   = 1;
  localparam int AST_M_STOP  = 0;

  localparam int AST_S_TXI_HI  = 15;
  localparam int AST_S_TXINV   = 14;
  localparam int AST_S_TXI_LO  = 13;
  localparam int AST_S_BRK     = 11;
  localparam int AST_S_TXEN    = 10;
  localparam int AST_S_TXFULL  = 9;
  localparam int AST_S_SHEMPTY = 8;
  localparam int AST_S_RXI     = 6;
  localparam int AST_S_ADDR    = 5;
  localparam int AST_S_RX_IDLE_FLAG   = 4;
  localparam int AST_S_PARITY_ERROR_FLAG    = 3;
  localparam int AST_S_FRAMING_ERROR_FLAG    = 2;
  localparam int AST_S_OVR     = 1;
  localparam int AST_S_AVAIL   = 0;

  localparam logic [1:0] AST_FMT_9N = 2'h3;
  localparam logic [1:0] AST_FMT_8O = 2'h2;
  localparam logic [1:0] AST_FMT_8E = 2'h1;

  localparam logic [1:0] AST_TXI_LOAD  = 2'h0;
  localparam logic [1:0] AST_TXI_DONE  = 2'h1;
  localparam logic [1:0] AST_TXI_EMPTY = 2'h2;
  localparam logic [1:0] AST_RXI_3Q    = 2'h2;
  localparam logic [1:0] AST_RXI_FULL  = 2'h3;

  localparam logic [3:0] AST_LAST_STD   = 4'hF;
  localparam logic [3:0] AST_LAST_HS    = 4'h3;
  localparam logic [3:0] AST_IR_PULSE   = 4'h3;
  localparam logic [4:0] AST_IR_HOLD    = 5'h10;
  localparam logic [3:0] AST_BRK_LAST   = 4'hB;
  localparam logic [3:0] AST_D9_LAST    = 4'h8;
  localparam logic [3:0] AST_D8_LAST    = 4'h7;
  localparam logic [2:0] AST_ABD_LAST   = 3'h4;
  localparam int         AST_ABD_SH_STD = 7;
  localparam int         AST_ABD_SH_HS  = 5;

  typedef struct packed {
    logic [AST_AW-1:0] addr;
    logic [AST_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } ast_bus_req_s;

  typedef struct packed {
    logic       framing_error_flag;
    logic       parity_error_flag;
    logic [8:0] data;
  } ast_rx_ent_s;

  typedef enum logic [2:0] {AST_TX_IDLE, AST_TX_START, AST_TX_DATA, AST_TX_PAR,
                            AST_TX_STOP} ast_txst_e;
  typedef enum logic [2:0] {AST_RX_IDLE, AST_RX_START, AST_RX_DATA, AST_RX_PAR,
                            AST_RX_STOP, AST_RX_ABD} ast_rxst_e;

  function automatic logic [3:0] ast_last_tick(input logic hs);
    return hs ? AST_LAST_HS : AST_LAST_STD;
  endfunction

  function automatic logic ast_has_par(input logic [1:0] fmt);
    return (fmt == AST_FMT_8O) || (fmt == AST_FMT_8E);
  endfunction

  function automatic logic ast_par_bit(input logic [8:0] d, input logic [1:0] fmt);
    return (^d[7:0]) ^ (fmt == AST_FMT_8O);
  endfunction

endpackage

/* rtl/ast_fifo.sv */
`timescale 1ns/1ps
module ast_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  // Fill and drain
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  // State
  output logic      [W-1:0]  head,
  output logic               full,
  output logic               empty,
  output logic      [CW-1:0] count
);
  import ast_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           rd;
    logic [PW-1:0]           wr;
    logic [CW-1:0]           cnt;
  } ast_fifo_state_s;

  ast_fifo_state_s s_q;
  ast_fifo_state_s s_d;
  logic            do_push;
  logic            do_pop;

  function automatic logic [PW-1:0] ast_fifo_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign full    = (s_q.cnt == CW'(DEPTH));
  assign empty   = (s_q.cnt == '0);
  assign count   = s_q.cnt;
  assign head    = s_q.mem[s_q.rd];
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;

  always_comb
  begin
    s_d = s_q;
    if (do_push)
    begin
      s_d.mem[s_q.wr] = push_data;
      s_d.wr          = ast_fifo_inc(s_q.wr);
    end
    if (do_pop)
      s_d.rd = ast_fifo_inc(s_q.rd);
    s_d.cnt = s_q.cnt + CW'(do_push) - CW'(do_pop);
    if (!nrst || flush)
    begin
      s_d.rd  = '0;
      s_d.wr  = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys)
    s_q <= s_d;

endmodule

/* rtl/ast_top.sv */
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module ast_top #(
  parameter int DEPTH = ast_pkg::AST_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  // Register port
  input  wire ast_pkg::ast_bus_req_s    bus_req,
  output logic [ast_pkg::AST_DW-1:0]    bus_rdata,
  // Serial line
  input  wire logic                     serial_in_pin,
  output logic                          serial_out_pin,
  output logic                          serial_out_oe,
  // Events
  output logic                          tx_irq,
  output logic                          rx_irq,
  output logic                          err_irq
);
  import ast_pkg::*;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] sta_w;
    logic        overrun;
    logic [15:0] divisor;
    logic [15:0] rdata;
    logic [15:0] bcnt;
    logic        btick;
    ast_txst_e   txst;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bit;
    logic [8:0]  tx_sh;
    logic        tx_par;
    logic        tx_brk;
    logic        tx_out;
    logic        tx_irq;
    ast_rxst_e   rxst;
    logic [1:0]  rx_sync;
    logic        rx_prev;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    logic        rx_parity_error_flag;
    logic [4:0]  ir_hold;
    logic [23:0] abd_cnt;
    logic [2:0]  abd_edges;
    logic        rx_irq;
  } ast_top_state_s;

  ast_top_state_s s_q;
  ast_top_state_s s_d;

  logic        en;
  logic        hs;
  logic        ir_on;
  logic        txen;
  logic        nine;
  logic [1:0]  fmt;
  logic [3:0]  last;
  logic        rx_src;
  logic        rx_pol;
  logic        rx_line;
  logic        rx_fall;
  logic        tx_line;
  logic        tx_bit_end;
  logic        rx_bit_end;
  logic        rx_half;
  logic [8:0]  rx_data;
  logic [23:0] abd_q;

  logic          tx_push;
  logic          tx_pop;
  logic          tx_flush;
  logic [8:0]    tx_head;
  logic          tx_full;
  logic          tx_empty;
  logic [CW-1:0] tx_count;
  logic          rx_push;
  logic          rx_pop;
  logic          rx_flush;
  ast_rx_ent_s   rx_ent;
  ast_rx_ent_s   rx_head;
  logic          rx_full;
  logic          rx_empty;
  logic [CW-1:0] rx_count;
  logic          ovr_set;
  logic          ovr_clr;
  logic [15:0]   sta_rd;

  assign en    = s_q.mode[AST_M_EN];
  assign hs    = s_q.mode[AST_M_HS];
  assign ir_on = s_q.mode[AST_M_IR] && !hs;
  assign txen  = s_q.sta_w[AST_S_TXEN];
  assign fmt   = s_q.mode[AST_M_FMT +: 2];
  assign nine  = (fmt == AST_FMT_9N);
  assign last  = ast_last_tick(hs);

  // Receive path: synchronised pin or own output, then polarity, then optional decoder
  assign rx_src  = s_q.mode[AST_M_LOOP] ? s_q.tx_out : s_q.rx_sync[1];
  assign rx_pol  = rx_src ^ s_q.mode[AST_M_RXINV];
  assign rx_line = ir_on ? (rx_pol && (s_q.ir_hold == '0)) : rx_pol;
  assign rx_fall = s_q.rx_prev && !rx_line;

  assign tx_bit_end = s_q.btick && (s_q.tx_sub == last);
  assign rx_bit_end = s_q.btick && (s_q.rx_sub == last);
  assign rx_half    = s_q.btick && (s_q.rx_sub == (last >> 1));
  assign rx_data    = nine ? s_q.rx_sh : {1'b0, s_q.rx_sh[8:1]};
  assign abd_q      = hs ? (s_q.abd_cnt >> AST_ABD_SH_HS) : (s_q.abd_cnt >> AST_ABD_SH_STD);

  always_comb
  begin
    unique case (s_q.txst)
      AST_TX_START: tx_line = 1'b0;
      AST_TX_DATA:  tx_line = s_q.tx_brk ? 1'b0 : s_q.tx_sh[0];
      AST_TX_PAR:   tx_line = s_q.tx_par;
      default:      tx_line = 1'b1;
    endcase
  end

  always_comb
  begin
    sta_rd                = s_q.sta_w & AST_STA_WMASK;
    sta_rd[AST_S_TXFULL]  = tx_full;
    sta_rd[AST_S_SHEMPTY] = tx_empty && (s_q.txst == AST_TX_IDLE);
    sta_rd[AST_S_RX_IDLE_FLAG]   = (s_q.rxst == AST_RX_IDLE);
    sta_rd[AST_S_PARITY_ERROR_FLAG]    = !rx_empty && rx_head.parity_error_flag;
    sta_rd[AST_S_FRAMING_ERROR_FLAG]    = !rx_empty && rx_head.framing_error_flag;
    sta_rd[AST_S_OVR]     = s_q.overrun;
    sta_rd[AST_S_AVAIL]   = !rx_empty;
  end

  always_comb
  begin
    s_d      = s_q;
    s_d.btick  = 1'b0;
    s_d.tx_irq = 1'b0;
    s_d.rx_irq = 1'b0;
    s_d.rdata  = '0;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    tx_flush = 1'b0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    rx_flush = 1'b0;
    rx_ent   = '0;
    ovr_set  = 1'b0;
    ovr_clr  = 1'b0;

    s_d.rx_sync = {s_q.rx_sync[0], serial_in_pin};
    s_d.rx_prev = rx_line;

    // Rate generator: one tick every divisor+1 clocks
    if (s_q.bcnt >= s_q.divisor)
    begin
      s_d.bcnt  = '0;
      s_d.btick = 1'b1;
    end
    else
      s_d.bcnt = s_q.bcnt + 16'h0001;

    // Decoder stretches a short pulse to a full bit of zero
    if (!rx_pol)
      s_d.ir_hold = AST_IR_HOLD;
    else if (s_q.btick && (s_q.ir_hold != '0))
      s_d.ir_hold = s_q.ir_hold - 5'h01;

    // Transmitter
    if (s_q.txst != AST_TX_IDLE && s_q.btick)
      s_d.tx_sub = tx_bit_end ? '0 : s_q.tx_sub + 4'h1;
    unique case (s_q.txst)
      AST_TX_IDLE:
      begin
        s_d.tx_sub = '0;
        s_d.tx_bit = '0;
        if (s_q.sta_w[AST_S_BRK])
        begin
          s_d.tx_brk = 1'b1;
          s_d.txst   = AST_TX_START;
        end
        else if (!tx_empty)
        begin
          tx_pop     = 1'b1;
          s_d.tx_sh  = nine ? tx_head : {1'b0, tx_head[7:0]};
          s_d.tx_par = ast_par_bit(tx_head, fmt);
          s_d.tx_brk = 1'b0;
          s_d.txst   = AST_TX_START;
          unique case ({s_q.sta_w[AST_S_TXI_HI], s_q.sta_w[AST_S_TXI_LO]})
            AST_TXI_LOAD:  s_d.tx_irq = 1'b1;
            AST_TXI_EMPTY: s_d.tx_irq = (tx_count == CW'(1));
            default:       s_d.tx_irq = 1'b0;
          endcase
        end
      end
      AST_TX_START:
        if (tx_bit_end)
          s_d.txst = AST_TX_DATA;
      AST_TX_DATA:
        if (tx_bit_end)
        begin
          s_d.tx_sh = s_q.tx_sh >> 1;
          if (s_q.tx_bit == (s_q.tx_brk ? AST_BRK_LAST : (nine ? AST_D9_LAST : AST_D8_LAST)))
          begin
            s_d.tx_bit = '0;
            s_d.txst   = (!s_q.tx_brk && ast_has_par(fmt)) ? AST_TX_PAR : AST_TX_STOP;
          end
          else
            s_d.tx_bit = s_q.tx_bit + 4'h1;
        end
      AST_TX_PAR:
        if (tx_bit_end)
          s_d.txst = AST_TX_STOP;
      AST_TX_STOP:
        if (tx_bit_end)
        begin
          // Break always ends with a single stop bit
          if (s_q.tx_bit == {3'h0, s_q.mode[AST_M_STOP] && !s_q.tx_brk})
          begin
            s_d.txst = AST_TX_IDLE;
            if (s_q.tx_brk)
              s_d.sta_w[AST_S_BRK] = 1'b0;
            s_d.tx_irq = tx_empty &&
                         ({s_q.sta_w[AST_S_TXI_HI], s_q.sta_w[AST_S_TXI_LO]} == AST_TXI_DONE);
          end
          else
            s_d.tx_bit = s_q.tx_bit + 4'h1;
        end
    endcase
    if (!en || !txen)
    begin
      s_d.txst   = AST_TX_IDLE;
      s_d.tx_irq = 1'b0;
      tx_pop     = 1'b0;
      tx_flush   = 1'b1;
    end

    // Encoder pulses for the first 3/16 of each zero bit
    if (ir_on)
      s_d.tx_out = (!tx_line && (s_q.tx_sub < AST_IR_PULSE)) ^ s_q.sta_w[AST_S_TXINV];
    else
      s_d.tx_out = tx_line ^ s_q.sta_w[AST_S_TXINV];

    // Receiver
    if (s_q.rxst != AST_RX_IDLE && s_q.rxst != AST_RX_ABD && s_q.btick)
      s_d.rx_sub = rx_bit_end ? '0 : s_q.rx_sub + 4'h1;
    unique case (s_q.rxst)
      AST_RX_IDLE:
      begin
        s_d.rx_sub  = '0;
        s_d.rx_bit  = '0;
        s_d.rx_parity_error_flag = 1'b0;
        // Edge-triggered start; sampling realigns on every start edge
        if (rx_fall)
        begin
          if (s_q.mode[AST_M_ABD])
          begin
            s_d.abd_cnt   = '0;
            s_d.abd_edges = 3'h1;
            s_d.rxst      = AST_RX_ABD;
          end
          else
            s_d.rxst = AST_RX_START;
        end
      end
      AST_RX_START:
        if (rx_half)
        begin
          s_d.rx_sub = '0;
          s_d.rxst   = rx_line ? AST_RX_IDLE : AST_RX_DATA;
        end
      AST_RX_DATA:
        if (rx_bit_end)
        begin
          s_d.rx_sh = {rx_line, s_q.rx_sh[8:1]};
          if (s_q.rx_bit == (nine ? AST_D9_LAST : AST_D8_LAST))
          begin
            s_d.rx_bit = '0;
            s_d.rxst   = ast_has_par(fmt) ? AST_RX_PAR : AST_RX_STOP;
          end
          else
            s_d.rx_bit = s_q.rx_bit + 4'h1;
        end
      AST_RX_PAR:
        if (rx_bit_end)
        begin
          s_d.rx_parity_error_flag = (rx_line != ast_par_bit(rx_data, fmt));
          s_d.rxst    = AST_RX_STOP;
        end
      AST_RX_STOP:
        if (rx_bit_end)
        begin
          s_d.rxst    = AST_RX_IDLE;
          rx_ent.data = rx_data;
          rx_ent.parity_error_flag = s_q.rx_parity_error_flag;
          rx_ent.framing_error_flag = !rx_line;
          if (!(nine && s_q.sta_w[AST_S_ADDR] && !rx_data[8]))
          begin
            if (rx_full)
              ovr_set = 1'b1;
            else
            begin
              rx_push = 1'b1;
              unique case (s_q.sta_w[AST_S_RXI +: 2])
                AST_RXI_FULL: s_d.rx_irq = (rx_count == CW'(DEPTH - 1));
                AST_RXI_3Q:   s_d.rx_irq = (rx_count == CW'(DEPTH - 2));
                default:      s_d.rx_irq = 1'b1;
              endcase
            end
          end
        end
      AST_RX_ABD:
      begin
        // Sync character has five falling edges spanning eight bit times
        if (s_q.abd_cnt != '1)
          s_d.abd_cnt = s_q.abd_cnt + 24'h000001;
        if (rx_fall)
        begin
          if (s_q.abd_edges == AST_ABD_LAST)
          begin
            s_d.divisor           = (abd_q == '0) ? '0 :
                                    (abd_q > 24'h00FFFF) ? 16'hFFFF : abd_q[15:0] - 16'h0001;
            s_d.mode[AST_M_ABD]   = 1'b0;
            s_d.rxst              = AST_RX_IDLE;
          end
          else
            s_d.abd_edges = s_q.abd_edges + 3'h1;
        end
      end
      default:
        s_d.rxst = AST_RX_IDLE;
    endcase

    // Register port
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        AST_OFS_MODE: s_d.mode = bus_req.wdata & AST_MODE_WMASK;
        AST_OFS_STA:
        begin
          s_d.sta_w = bus_req.wdata & AST_STA_WMASK;
          ovr_clr   = s_q.overrun && !bus_req.wdata[AST_S_OVR];
        end
        AST_OFS_TXD:  tx_push = en && txen;
        AST_OFS_DIV:  s_d.divisor = bus_req.wdata;
        default:      s_d.mode = s_d.mode;
      endcase
    end
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        AST_OFS_MODE: s_d.rdata = s_q.mode;
        AST_OFS_STA:  s_d.rdata = sta_rd;
        AST_OFS_RXD:
        begin
          s_d.rdata = {7'h00, rx_head.data};
          rx_pop    = !rx_empty;
        end
        AST_OFS_DIV:  s_d.rdata = s_q.divisor;
        default:      s_d.rdata = '0;
      endcase
    end

    // A new overflow wins over a clear in the same cycle
    s_d.overrun = ovr_set || (s_q.overrun && !ovr_clr);
    if (ovr_clr || !en)
    begin
      rx_flush   = 1'b1;
      rx_push    = 1'b0;
      rx_pop     = 1'b0;
      s_d.rxst   = AST_RX_IDLE;
      s_d.rx_irq = 1'b0;
    end

    if (!nrst)
    begin
      s_d         = '0;
      s_d.txst    = AST_TX_IDLE;
      s_d.rxst    = AST_RX_IDLE;
      s_d.tx_out  = 1'b1;
      s_d.rx_prev = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
    s_q <= s_d;

  ast_fifo #(
    .W     (9),
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .flush     (tx_flush),
    .push      (tx_push),
    .push_data (bus_req.wdata[8:0]),
    .pop       (tx_pop),
    .head      (tx_head),
    .full      (tx_full),
    .empty     (tx_empty),
    .count     (tx_count)
  );

  ast_fifo #(
    .W     ($bits(ast_rx_ent_s)),
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .flush     (rx_flush),
    .push      (rx_push),
    .push_data (rx_ent),
    .pop       (rx_pop),
    .head      (rx_head),
    .full      (rx_full),
    .empty     (rx_empty),
    .count     (rx_count)
  );

  assign bus_rdata      = s_q.rdata;
  assign serial_out_pin = s_q.tx_out;
  assign serial_out_oe  = en && txen;
  assign tx_irq         = s_q.tx_irq;
  assign rx_irq         = s_q.rx_irq;
  assign err_irq        = s_q.overrun || sta_rd[AST_S_PARITY_ERROR_FLAG] || sta_rd[AST_S_FRAMING_ERROR_FLAG];

endmodule

/* verification/ast_node.sv */
`timescale 1ns/1ps
module ast_node (
  // Clock
  input wire logic clk_sys,
  // Line
  input wire logic line_in,
  output logic     line_out
);
  int bt = 16;

  initial line_out = 1'b1;

  // Line is driven back to idle high after the last bit
  task automatic send(input logic [15:0] f, input int n);
    line_out <= 1'b0;
    repeat (bt) @(posedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      line_out <= f[i];
      repeat (bt) @(posedge clk_sys);
    end
    line_out <= 1'b1;
    @(posedge clk_sys);
  endtask

  // All ones when no start bit shows up
  task automatic grab(output logic [15:0] f);
    int k;
    f = 16'hFFFF;
    for (k = 0; k < 4000 && line_in !== 1'b0; k++)
      @(posedge clk_sys);
    if (k < 4000)
    begin
      repeat (bt + bt / 2 - 1) @(posedge clk_sys);
      for (int i = 0; i < 15; i++)
      begin
        f[i] = line_in;
        repeat (bt) @(posedge clk_sys);
      end
    end
  endtask
endmodule

/* verification/ast_top_asserts.sv */
`timescale 1ns/1ps
module ast_chk
  import ast_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  // Register port
  input wire ast_pkg::ast_bus_req_s bus_req,
  input wire logic [AST_DW-1:0]    bus_rdata,
  // Line and events
  input wire logic                 serial_in_pin,
  input wire logic                 serial_out_pin,
  input wire logic                 serial_out_oe,
  input wire logic                 tx_irq,
  input wire logic                 rx_irq,
  input wire logic                 err_irq
);
  logic [15:0] mode_q;
  logic [15:0] sta_q;

  // Only bits that hardware never clears are relied on
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      mode_q <= 16'h0;
      sta_q  <= 16'h0;
    end
    else if (bus_req.wr && bus_req.addr == AST_OFS_MODE)
      mode_q <= bus_req.wdata;
    else if (bus_req.wr && bus_req.addr == AST_OFS_STA)
      sta_q <= bus_req.wdata;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_sta_rd;
    bus_req.rd && bus_req.addr == AST_OFS_STA;
  endsequence
  sequence s_start;
    $fell(serial_out_pin) && !mode_q[AST_M_IR] && !sta_q[AST_S_TXINV];
  endsequence
  sequence s_hold8;
    $stable(serial_out_pin)[*8];
  endsequence

  property p_oe;
    serial_out_oe == (mode_q[AST_M_EN] && sta_q[AST_S_TXEN]);
  endproperty
  property p_bit16;
    disable iff (!nrst || !serial_out_oe)
    s_start ##0 !mode_q[AST_M_HS] |=> s_hold8 ##1 $stable(serial_out_pin)[*7];
  endproperty
  property p_bit4;
    disable iff (!nrst || !serial_out_oe)
    s_start ##0 mode_q[AST_M_HS] |=> $stable(serial_out_pin)[*3];
  endproperty
  property p_flags;
    s_sta_rd |=> !(bus_rdata[AST_S_TXFULL] && bus_rdata[AST_S_SHEMPTY]);
  endproperty
  property p_err;
    s_sta_rd |=> (|bus_rdata[3:1]) == $past(err_irq);
  endproperty
  property p_txirq;
    tx_irq |=> !tx_irq;
  endproperty
  property p_rxirq;
    rx_irq |=> !rx_irq;
  endproperty
  property p_reset_idle;
    $rose(nrst) |-> serial_out_pin && !serial_out_oe;
  endproperty

  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_bit16: assert property (p_bit16) else $error("short bit");
  a_bit4: assert property (p_bit4) else $error("short fast bit");
  a_flags: assert property (p_flags) else $error("full and empty");
  a_err: assert property (p_err) else $error("error event wrong");
  a_txirq: assert property (p_txirq) else $error("long tx event");
  a_rxirq: assert property (p_rxirq) else $error("long rx event");
  a_reset_idle: assert property (p_reset_idle) else $error("not idle");
endmodule

bind ast_top ast_chk u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq)
);

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ast_pkg::*;

  logic              clk_sys;
  logic              nrst;
  ast_bus_req_s      bus_req;
  logic [AST_DW-1:0] bus_rdata;
  logic              rx_line;
  logic              tx_line;
  logic              tx_oe;
  logic              tx_irq;
  logic              rx_irq;
  logic              err_irq;
  logic [1:0]        fm;
  logic [15:0]       d;
  logic [15:0]       e;
  logic [15:0]       f;
  logic [15:0]       m;
  int                fails = 0;
  int                num_checks = 0;
  int                seed = 32'h52f3;

  ast_top uut (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line), .serial_out_oe(tx_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
  ast_node node (.clk_sys(clk_sys), .line_in(tx_line), .line_out(rx_line));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] x);
    num_checks++;
    if (got !== x)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, x);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rc(input logic [4:0] a, input logic [15:0] x, input logic [15:0] mk);
    bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(posedge clk_sys);
    chk(bus_rdata & mk, x);
  endtask

  // Frame bits after start; one idle bit when s, then next start at 0
  function automatic logic [15:0] frame(input logic [8:0] v, input logic [1:0] fmt,
                                        input logic s, output logic [15:0] mk);
    int n;
    frame = {7'h0, v};
    n = (fmt == 2'h0) ? 8 : 9;
    if (fmt == 2'h1 || fmt == 2'h2)
      frame[8] = ^v[7:0] ^ fmt[1];
    frame[n] = 1'b1;
    frame[n + 1] = s;
    mk = (16'h1 << (n + 2 + s)) - 16'h1;
  endfunction

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end

  initial
  begin
    nrst = 1'b0;
    bus_req = '0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rc(AST_OFS_MODE, 16'h0000, 16'hFFFF);
    rc(AST_OFS_STA, 16'h0110, 16'hFFFF);
    rc(5'h14, 16'h0000, 16'hFFFF);
    for (int i = 0; i < 4; i++)
    begin
      fm = 2'(i);
      node.bt = (i == 3) ? 4 : 16;
      wr(AST_OFS_MODE, {8'h80, 4'h0, i == 3, fm, fm[0]});
      wr(AST_OFS_STA, {fm[1], 1'b0, fm[0], 2'b0, 1'b1, 10'h0});
      d = 16'($random(seed));
      wr(AST_OFS_TXD, d);
      wr(AST_OFS_TXD, ~d);
      node.grab(f);
      e = frame(d[8:0], fm, fm[0], m);
      chk(f & m, e);
      repeat (12 * node.bt) @(posedge clk_sys);
    end
    node.bt = 16;
    wr(AST_OFS_MODE, 16'h8000);
    wr(AST_OFS_STA, 16'h4400);
    repeat (2) @(posedge clk_sys);
    chk({15'h0, tx_line}, 16'h0000);
    wr(AST_OFS_STA, 16'h0400);
    for (int i = 0; i < 5; i++)
      wr(AST_OFS_TXD, 16'(i));
    rc(AST_OFS_STA, 16'h0200, 16'h0300);
    wr(AST_OFS_STA, 16'h0000);
    wr(AST_OFS_STA, 16'h0400);
    rc(AST_OFS_STA, 16'h0100, 16'h0300);
    wr(AST_OFS_STA, 16'h0C00);
    node.grab(f);
    chk(f & 16'h1FFF, 16'h1000);
    rc(AST_OFS_STA, 16'h0100, 16'h0900);
    for (int i = 0; i < 4; i++)
    begin
      fm = 2'(i);
      wr(AST_OFS_MODE, {13'h1000, fm, 1'b0});
      d = 16'($random(seed));
      e = frame(d[8:0], fm, 1'b1, m);
      f = e;
      f[8] = e[8] ^ !fm[0];
      node.send(f, $countones(m) - 1);
      rc(AST_OFS_STA, {12'h0, fm == 2'h2, fm == 2'h0, 2'b01}, 16'h000D);
      rc(AST_OFS_RXD, d & {7'h0, fm == 2'h3, 8'hFF}, {7'h0, fm == 2'h3, 8'hFF});
    end
    rc(AST_OFS_STA, 16'h0000, 16'h0001);
    wr(AST_OFS_MODE, 16'h8006);
    wr(AST_OFS_STA, 16'h0020);
    d = 16'($random(seed)) & 16'h00FF;
    e = frame(d[8:0], 2'h3, 1'b1, m);
    node.send(e, 11);
    node.send(e | 16'h0100, 11);
    rc(AST_OFS_RXD, d | 16'h0100, 16'h01FF);
    rc(AST_OFS_STA, 16'h0000, 16'h0001);
    wr(AST_OFS_MODE, 16'h8000);
    wr(AST_OFS_STA, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      node.send(frame(9'(i + 1), 2'h0, 1'b1, m), 10);
      if (i == 3)
        rc(AST_OFS_STA, 16'h0001, 16'h0003);
    end
    rc(AST_OFS_STA, 16'h0003, 16'h0003);
    chk({15'h0, err_irq}, 16'h0001);
    wr(AST_OFS_STA, 16'h0000);
    rc(AST_OFS_STA, 16'h0000, 16'h0003);
    chk({15'h0, err_irq}, 16'h0000);
    // Own output fed back: one plain frame must come round intact
    wr(AST_OFS_MODE, 16'h8040);
    wr(AST_OFS_STA, 16'h0400);
    wr(AST_OFS_TXD, d);
    repeat (200) @(posedge clk_sys);
    rc(AST_OFS_RXD, d & 16'h00FF, 16'h01FF);
    wr(AST_OFS_MODE, 16'h8020);
    node.bt = 40;
    node.send(16'h0355, 10);
    node.bt = 16;
    rc(AST_OFS_DIV, 16'h0001, 16'hFFFF);
    rc(AST_OFS_MODE, 16'h8000, 16'h8020);
    report_and_stop();
  end
endmodule
